// >>> fqg_axil_slave.sv
// AXI4-Lite slave front end producing a register write strobe and a read address
`include "fqg_map.svh"

module fqg_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`FQG_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [`FQG_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_en,
	output logic [`FQG_ADDR_W-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	output logic [`FQG_ADDR_W-1:0] rd_addr,
	input wire logic [31:0] rd_data
);

	logic rd_pend_reg;

	assign bresp = `FQG_RESP_OKAY;
	assign rresp = `FQG_RESP_OKAY;

	// ***********************************************************
	// Write channels
	// ***********************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			wr_en <= 1'b0;
			wr_addr <= '0;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			wr_en <= 1'b0;
			if (awvalid && awready) begin
				wr_addr <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wr_data <= wdata;
				wr_strb <= wstrb;
				wready <= 1'b0;
			end
			if (!awready && !wready && !bvalid) begin
				wr_en <= 1'b1;
				bvalid <= 1'b1;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// ***********************************************************
	// Read channels
	// ***********************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rd_pend_reg <= 1'b0;
			rd_addr <= '0;
			rdata <= 32'h0000_0000;
		end else begin
			if (arvalid && arready) begin
				rd_addr <= araddr;
				arready <= 1'b0;
				rd_pend_reg <= 1'b1;
			end
			if (rd_pend_reg) begin
				rdata <= rd_data;
				rvalid <= 1'b1;
				rd_pend_reg <= 1'b0;
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

endmodule

// >>> fqg_core.sv
// Flash query mode, identifier mode, write guard and status polling logic
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`include "fqg_map.svh"

module fqg_core #(
	parameter logic [`FQG_PWR_CNT_W-1:0] PWR_DLY_CYC = `FQG_PWR_CNT_W'(`FQG_PWR_DLY_CYC),
	// Identification values are arbitrary
	parameter logic [15:0] ID_MFR_CODE = 16'h00A5,
	parameter logic [15:0] ID_DEV_CODE = 16'h005A
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire fqg_pkg::fqg_host_bus_t host,
	input wire logic vcc_ok,
	input wire fqg_pkg::fqg_core_stat_t core_stat,
	input wire logic [15:0] array_rdata,
	output logic [15:0] dq_out,
	output logic dq_oe_n,
	output logic prog_start,
	output logic [21:0] prog_addr,
	output logic [15:0] prog_data,
	output logic irq,
	input wire logic [`FQG_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`FQG_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	logic wr_act;
	logic rd_act;
	logic rd_act_q;
	logic wr_pulse;
	logic [21:0] cap_addr_reg;
	logic [15:0] cap_data_reg;
	logic [7:0] wd;
	logic unlk1;
	logic cmd_query;
	logic cmd_ident;
	logic cmd_exit;
	logic cmd_cfg;
	logic cmd_prog;
	logic prog_allowed;
	logic prog_refused;
	fqg_pkg::fqg_seq_t seq_reg;
	fqg_pkg::fqg_mode_t mode_reg;
	logic [1:0] cfg_reg;
	logic [`FQG_PWR_CNT_W-1:0] pwr_cnt_reg;
	logic pwr_ready_reg;
	logic fail_hold_reg;
	logic stat_erase_reg;
	logic [1:0] stat_plane_reg;
	logic tog_reg;
	logic stat_active;
	logic plane_hit;
	logic [15:0] stat_word;
	logic [15:0] rd_word;
	logic [`FQG_IRQ_W-1:0] irq_stat_reg;
	logic [`FQG_IRQ_W-1:0] irq_mask_reg;
	logic [`FQG_IRQ_W-1:0] irq_set;
	logic [31:0] ctrl_reg;
	logic bus_wr_en;
	logic [`FQG_ADDR_W-1:0] bus_wr_addr;
	logic [31:0] bus_wr_data;
	logic [3:0] bus_wr_strb;
	logic [`FQG_ADDR_W-1:0] bus_rd_addr;
	logic [31:0] bus_rd_data;

	// ***********************************************************
	// Host strobes
	// ***********************************************************
	assign wr_act = !host.ce_n && !host.we_n && host.oe_n;
	assign rd_act = !host.ce_n && !host.oe_n && host.we_n;

	fqg_strobe_filter #(
		.MIN_CYC(`FQG_FILT_CYC)
	) u_wr_filter (
		.aclk(aclk),
		.aresetn(aresetn),
		.strobe_act(wr_act),
		.done_pulse(wr_pulse)
	);

	// Address and data as seen in the last active cycle of the strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_addr_reg <= 22'h00_0000;
			cap_data_reg <= 16'h0000;
		end else if (wr_act) begin
			cap_addr_reg <= host.addr;
			cap_data_reg <= host.data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_act_q <= 1'b0;
		end else begin
			rd_act_q <= rd_act;
		end
	end

	// ***********************************************************
	// Command decode
	// ***********************************************************
	assign wd = cap_data_reg[7:0];
	assign unlk1 = (wd == `FQG_UNLK1_DATA) && (cap_addr_reg[10:0] == `FQG_UNLK1_ADDR);
	assign cmd_query = wr_pulse && (seq_reg == fqg_pkg::FQG_SQ_IDLE)
		&& (wd == `FQG_QRY_DATA) && (cap_addr_reg[7:0] == `FQG_QRY_ADDR);
	assign cmd_ident = wr_pulse && (seq_reg == fqg_pkg::FQG_SQ_55) && (wd == `FQG_CMD_IDENT);
	assign cmd_exit = wr_pulse && (((seq_reg == fqg_pkg::FQG_SQ_IDLE) && !unlk1
		&& (wd[7:4] == `FQG_CMD_EXIT_NIB))
		|| ((seq_reg == fqg_pkg::FQG_SQ_55) && (wd == `FQG_CMD_EXIT)));
	assign cmd_cfg = wr_pulse && (seq_reg == fqg_pkg::FQG_SQ_CFG);
	assign cmd_prog = wr_pulse && (seq_reg == fqg_pkg::FQG_SQ_PROG);
	assign prog_allowed = vcc_ok && pwr_ready_reg && ctrl_reg[`FQG_CTRL_PROG_EN];
	assign prog_refused = cmd_prog && !prog_allowed;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq_reg <= fqg_pkg::FQG_SQ_IDLE;
		end else if (wr_pulse) begin
			case (seq_reg)
				fqg_pkg::FQG_SQ_IDLE: begin
					seq_reg <= unlk1 ? fqg_pkg::FQG_SQ_AA : fqg_pkg::FQG_SQ_IDLE;
				end
				fqg_pkg::FQG_SQ_AA: begin
					if ((wd == `FQG_UNLK2_DATA) && (cap_addr_reg[10:0] == `FQG_UNLK2_ADDR)) begin
						seq_reg <= fqg_pkg::FQG_SQ_55;
					end else begin
						seq_reg <= fqg_pkg::FQG_SQ_IDLE;
					end
				end
				fqg_pkg::FQG_SQ_55: begin
					if (wd == `FQG_CMD_CFG) begin
						seq_reg <= fqg_pkg::FQG_SQ_CFG;
					end else if (wd == `FQG_CMD_PROG) begin
						seq_reg <= fqg_pkg::FQG_SQ_PROG;
					end else begin
						seq_reg <= fqg_pkg::FQG_SQ_IDLE;
					end
				end
				default: begin
					seq_reg <= fqg_pkg::FQG_SQ_IDLE;
				end
			endcase
		end
	end

	// ***********************************************************
	// Read mode
	// ***********************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= fqg_pkg::FQG_MD_ARRAY;
		end else begin
			case (mode_reg)
				fqg_pkg::FQG_MD_ARRAY: begin
					if (cmd_query) begin
						mode_reg <= fqg_pkg::FQG_MD_QRY_A;
					end else if (cmd_ident) begin
						mode_reg <= fqg_pkg::FQG_MD_IDENT;
					end
				end
				fqg_pkg::FQG_MD_IDENT: begin
					if (cmd_query) begin
						mode_reg <= fqg_pkg::FQG_MD_QRY_I;
					end else if (cmd_exit) begin
						mode_reg <= fqg_pkg::FQG_MD_ARRAY;
					end
				end
				fqg_pkg::FQG_MD_QRY_A: begin
					if (cmd_exit) begin
						mode_reg <= fqg_pkg::FQG_MD_ARRAY;
					end
				end
				fqg_pkg::FQG_MD_QRY_I: begin
					if (cmd_exit) begin
						mode_reg <= fqg_pkg::FQG_MD_IDENT;
					end
				end
				default: begin
					mode_reg <= fqg_pkg::FQG_MD_ARRAY;
				end
			endcase
		end
	end

	// Only the configuration command moves this setting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg <= `FQG_CFG_RST;
		end else if (cmd_cfg && (wd[7:1] == 7'h00)) begin
			cfg_reg <= wd[1:0];
		end
	end

	// ***********************************************************
	// Write guard and program launch
	// ***********************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_cnt_reg <= '0;
			pwr_ready_reg <= 1'b0;
		end else if (!vcc_ok) begin
			pwr_cnt_reg <= '0;
			pwr_ready_reg <= 1'b0;
		end else if (pwr_cnt_reg < PWR_DLY_CYC) begin
			pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
		end else begin
			pwr_ready_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_start <= 1'b0;
			prog_addr <= 22'h00_0000;
			prog_data <= 16'h0000;
		end else begin
			prog_start <= cmd_prog && prog_allowed;
			if (cmd_prog && prog_allowed) begin
				prog_addr <= cap_addr_reg;
				prog_data <= cap_data_reg;
			end
		end
	end

	// ***********************************************************
	// Status polling
	// ***********************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fail_hold_reg <= 1'b0;
			stat_erase_reg <= 1'b0;
			stat_plane_reg <= 2'h0;
		end else begin
			if (core_stat.busy) begin
				stat_erase_reg <= core_stat.erase;
				stat_plane_reg <= core_stat.plane;
			end
			if (core_stat.fail) begin
				fail_hold_reg <= 1'b1;
			end else if (cmd_exit) begin
				fail_hold_reg <= 1'b0;
			end
		end
	end

	assign stat_active = core_stat.busy || fail_hold_reg;
	assign plane_hit = stat_active && (host.addr[21:20] == stat_plane_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tog_reg <= 1'b0;
		end else if (!stat_active) begin
			tog_reg <= 1'b0;
		end else if (core_stat.busy && rd_act && !rd_act_q && plane_hit) begin
			tog_reg <= !tog_reg;
		end
	end

	always_comb begin
		stat_word = 16'h0000;
		if (core_stat.busy) begin
			if (cfg_reg == `FQG_CFG_TOGGLE_ONLY) begin
				stat_word[`FQG_SB_POL] = 1'b0;
			end else begin
				stat_word[`FQG_SB_POL] = stat_erase_reg ? 1'b0 : !prog_data[7];
			end
		end else begin
			stat_word[`FQG_SB_POL] = (cfg_reg == `FQG_CFG_TOGGLE_ONLY) ? 1'b1 : prog_data[7];
		end
		stat_word[`FQG_SB_TOG] = tog_reg;
		stat_word[`FQG_SB_FAIL] = fail_hold_reg;
		stat_word[`FQG_SB_SUSP] = stat_erase_reg ? tog_reg : 1'b1;
	end

	always_comb begin
		rd_word = array_rdata;
		if (plane_hit) begin
			rd_word = stat_word;
		end else if ((mode_reg == fqg_pkg::FQG_MD_QRY_A) || (mode_reg == fqg_pkg::FQG_MD_QRY_I)) begin
			case (host.addr[7:0])
				`FQG_QT_Q_ADDR: rd_word = `FQG_QT_Q;
				`FQG_QT_R_ADDR: rd_word = `FQG_QT_R;
				`FQG_QT_Y_ADDR: rd_word = `FQG_QT_Y;
				default: rd_word = 16'h0000;
			endcase
		end else if (mode_reg == fqg_pkg::FQG_MD_IDENT) begin
			case (host.addr[7:0])
				`FQG_ID_MFR_ADDR: rd_word = ID_MFR_CODE;
				`FQG_ID_DEV_ADDR: rd_word = ID_DEV_CODE;
				default: rd_word = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dq_out <= 16'h0000;
			dq_oe_n <= 1'b1;
		end else begin
			dq_out <= rd_word;
			dq_oe_n <= !rd_act;
		end
	end

	// ***********************************************************
	// Register bus and interrupt
	// ***********************************************************
	fqg_axil_slave u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.wr_en(bus_wr_en),
		.wr_addr(bus_wr_addr),
		.wr_data(bus_wr_data),
		.wr_strb(bus_wr_strb),
		.rd_addr(bus_rd_addr),
		.rd_data(bus_rd_data)
	);

	always_comb begin
		irq_set = '0;
		irq_set[`FQG_IRQ_QUERY] = cmd_query;
		irq_set[`FQG_IRQ_BLOCKED] = prog_refused;
		irq_set[`FQG_IRQ_FAIL] = core_stat.fail && !fail_hold_reg;
		irq_set[`FQG_IRQ_PROG] = cmd_prog && prog_allowed;
	end

	// Set wins over a one-to-clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_reg <= '0;
		end else if (bus_wr_en && (bus_wr_addr == `FQG_OFF_IRQ_STAT) && bus_wr_strb[0]) begin
			irq_stat_reg <= (irq_stat_reg & ~bus_wr_data[`FQG_IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_reg <= '0;
			ctrl_reg <= `FQG_CTRL_RST;
		end else if (bus_wr_en && bus_wr_strb[0]) begin
			if (bus_wr_addr == `FQG_OFF_IRQ_MASK) begin
				irq_mask_reg <= bus_wr_data[`FQG_IRQ_W-1:0];
			end
			if (bus_wr_addr == `FQG_OFF_CTRL) begin
				ctrl_reg <= {31'h0000_0000, bus_wr_data[`FQG_CTRL_PROG_EN]};
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	always_comb begin
		case (bus_rd_addr)
			`FQG_OFF_IRQ_STAT: bus_rd_data = {28'h000_0000, irq_stat_reg};
			`FQG_OFF_IRQ_MASK: bus_rd_data = {28'h000_0000, irq_mask_reg};
			`FQG_OFF_CTRL: bus_rd_data = ctrl_reg;
			`FQG_OFF_STATE: bus_rd_data = {22'h00_0000, stat_plane_reg, fail_hold_reg,
				core_stat.busy, pwr_ready_reg, cfg_reg, mode_reg, 1'b0};
			default: bus_rd_data = 32'h0000_0000;
		endcase
	end

endmodule

// >>> fqg_core_bench.sv
// Self-checking bench for the flash query/write guard core
`include "fqg_map.svh"

module fqg_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] STA = `FQG_OFF_IRQ_STAT;
	localparam logic [7:0] MSK = `FQG_OFF_IRQ_MASK;
	localparam logic [7:0] CTL = `FQG_OFF_CTRL;
	localparam logic [7:0] STE = `FQG_OFF_STATE;
	localparam logic [15:0] AD = 16'h0010 ^ 16'h3C3C;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic vcc_ok = 1'b0;
	fqg_pkg::fqg_host_bus_t host;
	fqg_pkg::fqg_core_stat_t core_stat = '0;
	logic [15:0] array_rdata, dq_out, prog_data, d1, d2;
	logic dq_oe_n, prog_start, irq, awready, wready, bvalid, arready, rvalid;
	logic [21:0] prog_addr;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, r;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [1:0] bresp, rresp;
	int n_fail = 0, comparisons = 0, n_prog = 0;
	always #20 aclk = ~aclk;
	assign array_rdata = host.addr[15:0] ^ 16'h3C3C;
	always @(posedge aclk) if (prog_start === 1'b1) n_prog <= n_prog + 1;
	fqg_core #(.PWR_DLY_CYC(`FQG_PWR_CNT_W'(60))) i_fqg_core (.aclk(aclk), .aresetn(aresetn),
		.host(host), .vcc_ok(vcc_ok), .core_stat(core_stat), .array_rdata(array_rdata),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .prog_start(prog_start), .prog_addr(prog_addr),
		.prog_data(prog_data), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	fqg_host_model i_fqg_host_model (.aclk(aclk), .dq_out(dq_out), .host(host));
	// ***********************************************************
	// Access and compare tasks
	// ***********************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) bready <= 1'b0;
		end while (!(bready && bvalid));
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		r = rdata;
		chk({30'h0, rresp}, {30'h0, `FQG_RESP_OKAY});
		rready <= 1'b0;
		chk(r & m, e);
	endtask
	task automatic qchk(input logic [21:0] a, input logic [15:0] m, input logic [15:0] e);
		i_fqg_host_model.rd(a, d1);
		chk({16'h0, d1 & m}, {16'h0, e});
	endtask
	task automatic hw(input logic [21:0] a, input logic [15:0] d);
		i_fqg_host_model.wr(a, d, 1'b0);
	endtask
	task automatic cmd3(input logic [15:0] d);
		hw(22'h555, 16'h00AA);
		hw(22'hAAA, 16'h0055);
		hw(22'h555, d);
	endtask
	task automatic prog(input logic oe_low);
		cmd3(16'h00A0);
		i_fqg_host_model.wr(22'h100010, 16'h00C3, oe_low);
	endtask
	task automatic tally_and_finish;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail = n_fail + 1;
		tally_and_finish;
	end
	// ***********************************************************
	// Test sequence
	// ***********************************************************
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(STA, 32'hF, 32'h0);
		rchk(MSK, 32'hF, 32'h0);
		rchk(CTL, 32'h1, `FQG_CTRL_RST);
		rchk(STE, 32'h1E, 32'h0);
		axw(8'h40, 32'hFFFF_FFFF);
		rchk(8'h40, 32'hFFFF_FFFF, 32'h0);
		prog(1'b0);
		chk(n_prog, 32'h0);
		rchk(STA, 32'h2, 32'h2);
		vcc_ok <= 1'b1;
		prog(1'b0);
		chk(n_prog, 32'h0);
		repeat (60) @(posedge aclk);
		prog(1'b1);
		chk(n_prog, 32'h0);
		axw(CTL, 32'h0);
		// The cancelled program leaves its data cycle pending; spend it while disabled
		hw(22'h0, 16'h0000);
		prog(1'b0);
		chk(n_prog, 32'h0);
		axw(CTL, 32'h1);
		prog(1'b0);
		chk(n_prog, 32'h1);
		chk({10'h0, prog_addr}, {10'h0, 22'h100010});
		chk({16'h0, prog_data}, 32'h0000_00C3);
		rchk(STA, 32'hF, 32'hA);
		chk({31'h0, irq}, 32'h0);
		axw(MSK, 32'hF);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		axw(STA, 32'hF);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		core_stat <= '{1'b1, 1'b0, 2'h1, 1'b0};
		qchk(22'h100010, 16'h00A4, 16'h0004);
		d2 = d1;
		i_fqg_host_model.rd(22'h1000FF, d1);
		chk({31'h0, d1[6] ^ d2[6]}, 32'h1);
		qchk(22'h200010, 16'hFFFF, AD);
		core_stat <= '{1'b1, 1'b1, 2'h1, 1'b0};
		qchk(22'h100010, 16'h0080, 16'h0000);
		d2 = d1;
		i_fqg_host_model.rd(22'h100010, d1);
		chk({30'h0, d1[6] ^ d2[6], d1[2] ^ d2[2]}, 32'h3);
		core_stat <= '{1'b0, 1'b0, 2'h1, 1'b1};
		@(posedge aclk);
		core_stat <= '0;
		qchk(22'h100010, 16'h00A0, 16'h00A0);
		rchk(STA, 32'h4, 32'h4);
		hw(22'h0, 16'h00F0);
		qchk(22'h100010, 16'hFFFF, AD);
		cmd3(16'h00E0);
		hw(22'h0, 16'h0001);
		rchk(STE, 32'h18, 32'h8);
		cmd3(16'h00E0);
		hw(22'h0, 16'h0002);
		rchk(STE, 32'h18, 32'h8);
		core_stat <= '{1'b1, 1'b0, 2'h1, 1'b0};
		qchk(22'h100010, 16'h0080, 16'h0000);
		core_stat <= '{1'b0, 1'b0, 2'h1, 1'b1};
		@(posedge aclk);
		core_stat <= '0;
		qchk(22'h100010, 16'h00E0, 16'h00A0);
		hw(22'h0, 16'h00F0);
		hw(22'h000055, 16'h0098);
		rchk(STE, 32'h6, 32'h4);
		qchk(22'h10, 16'hFFFF, `FQG_QT_Q);
		qchk(22'h11, 16'hFFFF, `FQG_QT_R);
		hw(22'h000123, 16'h0012);
		rchk(STE, 32'h6, 32'h4);
		hw(22'h0, 16'h00F0);
		rchk(STE, 32'h6, 32'h0);
		cmd3(16'h0090);
		qchk(22'h0, 16'hFFFF, 16'h00A5);
		hw(22'h3FFF55, 16'h0098);
		rchk(STE, 32'h6, 32'h6);
		qchk(22'h12, 16'hFFFF, `FQG_QT_Y);
		hw(22'h0, 16'h00F0);
		rchk(STE, 32'h6, 32'h2);
		qchk(22'h1, 16'hFFFF, 16'h005A);
		cmd3(16'h00F0);
		rchk(STE, 32'h6, 32'h0);
		rchk(STA, 32'h1, 32'h1);
		tally_and_finish;
	end
endmodule

// >>> fqg_core_chk.sv
// Concurrent checks on the flash query/write guard core ports
`include "fqg_map.svh"

module fqg_core_chk #(
	parameter logic [`FQG_PWR_CNT_W-1:0] PWR_DLY_CYC = `FQG_PWR_CNT_W'(`FQG_PWR_DLY_CYC)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire fqg_pkg::fqg_host_bus_t host,
	input wire logic vcc_ok,
	input wire logic dq_oe_n,
	input wire logic prog_start,
	input wire logic [21:0] prog_addr,
	input wire logic [15:0] prog_data,
	input wire logic irq,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	// ***********************************************************
	// Helper counters
	// ***********************************************************
	logic wr_act;
	logic rd_act;
	logic [19:0] pwr_age;
	logic [3:0] wr_age;
	assign wr_act = !host.ce_n && !host.we_n && host.oe_n;
	assign rd_act = !host.ce_n && !host.oe_n && host.we_n;
	always_ff @(posedge aclk) begin
		if (!aresetn || !vcc_ok) begin
			pwr_age <= 20'h0;
		end else if (pwr_age != 20'hFFFFF) begin
			pwr_age <= pwr_age + 20'h1;
		end
	end
	// Cycles since the last sampled write strobe, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_age <= 4'hF;
		end else if (wr_act) begin
			wr_age <= 4'h0;
		end else if (wr_age != 4'hF) begin
			wr_age <= wr_age + 4'h1;
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ***********************************************************
	// Assertions
	// ***********************************************************
	rst_idle_a: assert property ($rose(aresetn) |->
		dq_oe_n && !prog_start && !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not idle after reset");
	prog_power_a: assert property (prog_start |-> pwr_age >= {2'b00, PWR_DLY_CYC})
		else $error("program launched before supply settled");
	prog_strobe_a: assert property (prog_start |-> wr_age inside {[4'h1:4'h5]})
		else $error("program launched without a write strobe");
	prog_once_a: assert property (prog_start |=> !prog_start)
		else $error("program launch longer than one cycle");
	prog_hold_a: assert property ($changed(prog_addr) || $changed(prog_data) |-> prog_start)
		else $error("program address or data moved without launch");
	dq_drive_a: assert property (rd_act |=> !dq_oe_n)
		else $error("read strobe not answered");
	dq_float_a: assert property (!rd_act |=> dq_oe_n)
		else $error("data driven without read strobe");
	b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	b_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == `FQG_RESP_OKAY)
		else $error("write response not okay");
	r_lat_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
		else $error("read answer late");
	r_end_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
endmodule

bind fqg_core fqg_core_chk #(.PWR_DLY_CYC(PWR_DLY_CYC)) i_fqg_core_chk (.aclk, .aresetn,
	.host, .vcc_ok, .dq_oe_n, .prog_start, .prog_addr, .prog_data, .irq, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready);

// >>> fqg_host_model.sv
// Behavioural flash host making write and read strobe cycles
module fqg_host_model (
	input wire logic aclk,
	input wire logic [15:0] dq_out,
	output fqg_pkg::fqg_host_bus_t host
);
	timeunit 1ns;
	timeprecision 1ps;
	initial host = '{1'b1, 1'b1, 1'b1, 22'h0, 16'h0};
	// After a write the released data lines show the inverse of the written value; a read leaves them as driven during its strobe
	task automatic wr(input logic [21:0] a, input logic [15:0] d, input logic oe_low);
		@(posedge aclk);
		host <= '{1'b0, ~oe_low, 1'b0, a, d};
		@(posedge aclk);
		host <= '{1'b1, 1'b1, 1'b1, a, ~d};
		repeat (4) @(posedge aclk);
	endtask
	task automatic rd(input logic [21:0] a, output logic [15:0] d);
		@(posedge aclk);
		host <= '{1'b0, 1'b0, 1'b1, a, ~host.data};
		repeat (2) @(posedge aclk);
		d = dq_out;
		host <= '{1'b1, 1'b1, 1'b1, a, host.data};
	endtask
endmodule

// >>> fqg_map.svh
// Register offsets, field positions, reset values and timing counts of the flash query/write guard
`ifndef FQG_MAP_SVH
`define FQG_MAP_SVH

// ***********************************************************
// Register bus map
// ***********************************************************
`define FQG_ADDR_W 8
`define FQG_OFF_IRQ_STAT 8'h00
`define FQG_OFF_IRQ_MASK 8'h04
`define FQG_OFF_CTRL 8'h08
`define FQG_OFF_STATE 8'h0C
`define FQG_IRQ_W 4
`define FQG_IRQ_QUERY 0
`define FQG_IRQ_BLOCKED 1
`define FQG_IRQ_FAIL 2
`define FQG_IRQ_PROG 3
`define FQG_CTRL_PROG_EN 0
`define FQG_CTRL_RST 32'h0000_0001
`define FQG_RESP_OKAY 2'h0

// ***********************************************************
// Command encodings
// ***********************************************************
`define FQG_QRY_ADDR 8'h55
`define FQG_QRY_DATA 8'h98
`define FQG_UNLK1_ADDR 11'h555
`define FQG_UNLK1_DATA 8'hAA
`define FQG_UNLK2_ADDR 11'h2AA
`define FQG_UNLK2_DATA 8'h55
`define FQG_CMD_IDENT 8'h90
`define FQG_CMD_EXIT 8'hF0
`define FQG_CMD_EXIT_NIB 4'hF
`define FQG_CMD_CFG 8'hE0
`define FQG_CMD_PROG 8'hA0
`define FQG_CFG_RST 2'h0
`define FQG_CFG_TOGGLE_ONLY 2'h1

// ***********************************************************
// Status bit positions and query table
// ***********************************************************
`define FQG_SB_POL 7
`define FQG_SB_TOG 6
`define FQG_SB_FAIL 5
`define FQG_SB_SUSP 2
`define FQG_QT_Q_ADDR 8'h10
`define FQG_QT_R_ADDR 8'h11
`define FQG_QT_Y_ADDR 8'h12
`define FQG_QT_Q 16'h0051
`define FQG_QT_R 16'h0052
`define FQG_QT_Y 16'h0059
`define FQG_ID_MFR_ADDR 8'h00
`define FQG_ID_DEV_ADDR 8'h01

// ***********************************************************
// Timing
// ***********************************************************
`define FQG_CLK_KHZ 25000
`define FQG_FILT_NS 15
`define FQG_FILT_CYC (((`FQG_FILT_NS * `FQG_CLK_KHZ) + 999999) / 1000000)
`define FQG_PWR_DLY_MS 10
`define FQG_PWR_DLY_CYC (`FQG_PWR_DLY_MS * `FQG_CLK_KHZ)
`define FQG_PWR_CNT_W 18

`endif

// >>> fqg_pkg.sv
// Types shared by the flash query/write guard modules
package fqg_pkg;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [21:0] addr;
		logic [15:0] data;
	} fqg_host_bus_t;

	typedef struct packed {
		logic busy;
		logic erase;
		logic [1:0] plane;
		logic fail;
	} fqg_core_stat_t;

	typedef enum logic [1:0] {
		FQG_MD_ARRAY,
		FQG_MD_IDENT,
		FQG_MD_QRY_A,
		FQG_MD_QRY_I
	} fqg_mode_t;

	typedef enum logic [2:0] {
		FQG_SQ_IDLE,
		FQG_SQ_AA,
		FQG_SQ_55,
		FQG_SQ_CFG,
		FQG_SQ_PROG
	} fqg_seq_t;

endpackage

// >>> fqg_strobe_filter.sv
// Strobe noise filter: reports the end of a strobe held active long enough
module fqg_strobe_filter #(
	parameter int MIN_CYC = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic strobe_act,
	output logic done_pulse
);

	logic [3:0] cnt_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= 4'h0;
		end else if (strobe_act) begin
			if (cnt_reg < 4'(MIN_CYC)) begin
				cnt_reg <= cnt_reg + 4'h1;
			end
		end else begin
			cnt_reg <= 4'h0;
		end
	end

	// Short glitches drop out before reaching the count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_pulse <= 1'b0;
		end else begin
			done_pulse <= !strobe_act && (cnt_reg >= 4'(MIN_CYC));
		end
	end

endmodule
